//--- hw/psleb_defines.svh
// Register offsets, field masks and reset values of the peripheral sleep-enable bank
`ifndef PSLEB_DEFINES_SVH
`define PSLEB_DEFINES_SVH

// ==========================================================
// Register map
`define PSLEB_OFS_SLEEP_EN2      12'h024
`define PSLEB_OFS_CLK_REQ2       12'h028
`define PSLEB_ADDR_W             12

// ==========================================================
// Field masks
`define PSLEB_SLEEP_RESET        32'h0000_0000
`define PSLEB_WRITE_MASK         32'h1FFF_FFF8
`define PSLEB_PERIPH_MASK        32'h1FFF_FE08
`define PSLEB_VENDOR_MASK        32'h0000_01F0
`define PSLEB_BIT_CRYPTO         28
`define PSLEB_BIT_RANDOM         27
`define PSLEB_BIT_PUBKEY         26

// ==========================================================
// Bus responses
`define PSLEB_RESP_OKAY          2'h0
`define PSLEB_RESP_SLVERR        2'h2

`endif

//--- hw/psleb_pkg.sv
// Types shared by the peripheral sleep-enable bank
package psleb_pkg;
	typedef logic [31:0] psleb_word_t;
	typedef enum logic [1:0] {PSLEB_W_IDLE, PSLEB_W_RESP} psleb_wstate_t;
endpackage : psleb_pkg

//--- hw/psleb_gate_cell.sv
// Per-peripheral clock gate request cell with registered output
`timescale 1ns/1ps
`default_nettype none
module psleb_gate_cell (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic sleep_en,
	input  wire logic clk_req,
	output var  logic gate_off_ff
);
	// Gate only while sleep commanded and clock no longer required
	logic nxt_gate_off;
	assign nxt_gate_off = sleep_en & ~clk_req;

	// Registered gate request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_off_ff <= 1'b0;
		end else begin
			gate_off_ff <= nxt_gate_off;
		end
	end
endmodule : psleb_gate_cell
`default_nettype wire

//--- hw/psleb_top.sv
// Peripheral sleep-enable bank with AXI4-Lite register slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "psleb_defines.svh"

module psleb_top (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [11:0]               s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output var  logic                      s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output var  logic                      s_axi_wready,
	output var  logic [1:0]                s_axi_bresp,
	output var  logic                      s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [11:0]               s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output var  logic                      s_axi_arready,
	output var  logic [31:0]               s_axi_rdata,
	output var  logic [1:0]                s_axi_rresp,
	output var  logic                      s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic [31:0]               periph_clk_req,
	input  wire logic                      other_groups_asleep,
	output var  logic [31:0]               sleep_cmd_ff,
	output var  logic [31:0]               clk_gate_off_ff,
	output var  logic                      random_power_off_ff,
	output var  logic                      crypto_reg_block_ff,
	output var  logic                      pubkey_reg_block_ff,
	output var  logic                      sys_sleep_ok_ff
);
	// ==========================================================
	// Register storage
	psleb_pkg::psleb_word_t sleep_en_ff;
	psleb_pkg::psleb_word_t nxt_sleep_en;
	psleb_pkg::psleb_word_t clk_req_eff;
	psleb_pkg::psleb_wstate_t wstate_ff;
	logic                   aw_have_ff;
	logic                   w_have_ff;
	logic [11:0]            aw_addr_ff;
	logic [31:0]            w_data_ff;
	logic [3:0]             w_strb_ff;
	logic [11:0]            ar_addr_ff;
	logic                   ar_have_ff;

	// Byte-lane merge used for writes
	function automatic logic [31:0] psleb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : psleb_merge

	// ==========================================================
	// Write channel decode
	logic aw_take;
	logic w_take;
	logic wr_fire;
	logic wr_hit;
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take  = s_axi_wvalid & s_axi_wready;
	assign wr_fire = (wstate_ff == psleb_pkg::PSLEB_W_IDLE) & (aw_have_ff | aw_take) & (w_have_ff | w_take);
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	assign wr_addr = aw_take ? s_axi_awaddr : aw_addr_ff;
	assign wr_data = w_take ? s_axi_wdata : w_data_ff;
	assign wr_strb = w_take ? s_axi_wstrb : w_strb_ff;
	assign wr_hit  = (wr_addr[11:2] == 10'(`PSLEB_OFS_SLEEP_EN2 >> 2));
	// Only defined bits store; 31:29 and 2:0 read zero
	assign nxt_sleep_en = (wr_fire && wr_hit) ?
		(psleb_merge(sleep_en_ff, wr_data, wr_strb) & `PSLEB_WRITE_MASK) : sleep_en_ff;

	// Address and data captured in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			aw_addr_ff <= 12'h000;
			w_data_ff  <= 32'h0000_0000;
			w_strb_ff  <= 4'h0;
		end else begin
			aw_have_ff <= wr_fire ? 1'b0 : (aw_have_ff | aw_take);
			w_have_ff  <= wr_fire ? 1'b0 : (w_have_ff | w_take);
			if (aw_take) begin
				aw_addr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
		end
	end

	// Write response state and the sleep register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstate_ff     <= psleb_pkg::PSLEB_W_IDLE;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PSLEB_RESP_OKAY;
			sleep_en_ff   <= `PSLEB_SLEEP_RESET;
		end else begin
			sleep_en_ff <= nxt_sleep_en;
			unique case (wstate_ff)
				psleb_pkg::PSLEB_W_IDLE: begin
					if (wr_fire) begin
						wstate_ff    <= psleb_pkg::PSLEB_W_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= wr_hit ? `PSLEB_RESP_OKAY : `PSLEB_RESP_SLVERR;
					end
				end
				psleb_pkg::PSLEB_W_RESP: begin
					if (s_axi_bready) begin
						wstate_ff    <= psleb_pkg::PSLEB_W_IDLE;
						s_axi_bvalid <= 1'b0;
					end
				end
			endcase
		end
	end

	// Ready while the holding slot is empty and no response pending
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= ~(aw_have_ff | aw_take) & ~wr_fire & (wstate_ff == psleb_pkg::PSLEB_W_IDLE)
				& ~(s_axi_bvalid & ~s_axi_bready);
			s_axi_wready  <= ~(w_have_ff | w_take) & ~wr_fire & (wstate_ff == psleb_pkg::PSLEB_W_IDLE)
				& ~(s_axi_bvalid & ~s_axi_bready);
		end
	end

	// ==========================================================
	// Read channel
	logic ar_take;
	logic rd_sleep_hit;
	logic rd_req_hit;
	assign ar_take      = s_axi_arvalid & s_axi_arready;
	assign rd_sleep_hit = (ar_addr_ff[11:2] == 10'(`PSLEB_OFS_SLEEP_EN2 >> 2));
	assign rd_req_hit   = (ar_addr_ff[11:2] == 10'(`PSLEB_OFS_CLK_REQ2 >> 2));
	// Random source drops its request once powered off; only defined bits show
	assign clk_req_eff  = periph_clk_req & `PSLEB_PERIPH_MASK
		& ~({31'h0, random_power_off_ff} << `PSLEB_BIT_RANDOM);

	// Read address accept, then data one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			ar_have_ff    <= 1'b0;
			ar_addr_ff    <= 12'h000;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `PSLEB_RESP_OKAY;
		end else begin
			s_axi_arready <= ~ar_have_ff & ~ar_take & ~s_axi_rvalid;
			if (ar_take) begin
				ar_addr_ff <= s_axi_araddr;
				ar_have_ff <= 1'b1;
			end else if (ar_have_ff) begin
				ar_have_ff   <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= (rd_sleep_hit | rd_req_hit) ? `PSLEB_RESP_OKAY : `PSLEB_RESP_SLVERR;
				s_axi_rdata  <= rd_sleep_hit ? sleep_en_ff : (rd_req_hit ? clk_req_eff : 32'h0000_0000);
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Peripheral control outputs
	logic all_asleep;
	logic none_req;
	assign all_asleep = ((sleep_en_ff & `PSLEB_PERIPH_MASK) == `PSLEB_PERIPH_MASK) & other_groups_asleep;
	assign none_req   = (clk_req_eff == 32'h0000_0000);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_cmd_ff        <= 32'h0000_0000;
			random_power_off_ff <= 1'b0;
			crypto_reg_block_ff <= 1'b0;
			pubkey_reg_block_ff <= 1'b0;
			sys_sleep_ok_ff     <= 1'b0;
		end else begin
			sleep_cmd_ff        <= sleep_en_ff & `PSLEB_PERIPH_MASK;
			random_power_off_ff <= sleep_en_ff[`PSLEB_BIT_RANDOM];
			// Register interface blocked once engine actually asleep
			crypto_reg_block_ff <= sleep_en_ff[`PSLEB_BIT_CRYPTO] & ~periph_clk_req[`PSLEB_BIT_CRYPTO];
			pubkey_reg_block_ff <= sleep_en_ff[`PSLEB_BIT_PUBKEY] & ~periph_clk_req[`PSLEB_BIT_PUBKEY];
			sys_sleep_ok_ff     <= all_asleep & none_req;
		end
	end

	// Only peripheral bits may gate; vendor storage bits never do
	psleb_pkg::psleb_word_t gate_sleep;
	assign gate_sleep = sleep_en_ff & `PSLEB_PERIPH_MASK;

	// One gate cell per bit; cells on undefined bits stay open
	for (genvar g = 0; g < 32; g++) begin : g_gate
		psleb_gate_cell u_cell (
			.aclk        (aclk),
			.aresetn     (aresetn),
			.sleep_en    (gate_sleep[g]),
			.clk_req     (clk_req_eff[g]),
			.gate_off_ff (clk_gate_off_ff[g])
		);
	end

	// ==========================================================
	// Checks
	property p_rst_zero;
		@(posedge aclk) $fell(aresetn) |=> (sleep_en_ff == 32'h0000_0000);
	endproperty
	a_rst_zero: assert property (p_rst_zero) else $error("sleep register not cleared by reset");
	property p_crypto_block;
		@(posedge aclk) disable iff (!aresetn)
		(sleep_en_ff[28] && !periph_clk_req[28]) |=> crypto_reg_block_ff;
	endproperty
	a_crypto_block: assert property (p_crypto_block) else $error("crypto registers not blocked");
	property p_pubkey_block;
		@(posedge aclk) disable iff (!aresetn) !sleep_en_ff[26] |=> !pubkey_reg_block_ff;
	endproperty
	a_pubkey_block: assert property (p_pubkey_block) else $error("pubkey blocked while awake");
	property p_random_off;
		@(posedge aclk) disable iff (!aresetn) $rose(sleep_en_ff[27]) |=> random_power_off_ff ##1 !clk_req_eff[27];
	endproperty
	a_random_off: assert property (p_random_off) else $error("random source not powered off");
	property p_cmd_hi;
		@(posedge aclk) disable iff (!aresetn) 1'b1 |=> (sleep_cmd_ff[25:16] == $past(sleep_en_ff[25:16]));
	endproperty
	a_cmd_hi: assert property (p_cmd_hi) else $error("sleep command 25..16 wrong");
	property p_cmd_lo;
		@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> (sleep_cmd_ff[15:0] == ($past(sleep_en_ff[15:0]) & 16'hFE08));
	endproperty
	a_cmd_lo: assert property (p_cmd_lo) else $error("sleep command 15..3 wrong");
	property p_vendor_store;
		@(posedge aclk) disable iff (!aresetn)
		(wr_fire && wr_hit && wr_strb[1:0] == 2'h3) |=> (sleep_en_ff[8:4] == $past(wr_data[8:4]));
	endproperty
	a_vendor_store: assert property (p_vendor_store) else $error("vendor bits not stored");
	property p_sys_sleep;
		@(posedge aclk) disable iff (!aresetn) sys_sleep_ok_ff |-> $past(none_req && all_asleep);
	endproperty
	a_sys_sleep: assert property (p_sys_sleep) else $error("system sleep allowed early");
	property p_req_read;
		@(posedge aclk) disable iff (!aresetn)
		(ar_have_ff && rd_req_hit) |=> (s_axi_rvalid && s_axi_rdata == $past(clk_req_eff));
	endproperty
	a_req_read: assert property (p_req_read) else $error("clock-required read wrong");
	property p_gate;
		@(posedge aclk) disable iff (!aresetn) !sleep_en_ff[9] |=> !clk_gate_off_ff[9];
	endproperty
	a_gate: assert property (p_gate) else $error("clock gated while awake");

	// Storage, status and gating checks; random power-off and gate restore check one bit each
	property p_reserved_zero;
		@(posedge aclk) disable iff (!aresetn)
		(sleep_en_ff[31:29] == 3'h0) && (sleep_en_ff[2:0] == 3'h0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved sleep bits not zero");
	property p_status_ro;
		@(posedge aclk) disable iff (!aresetn)
		(wr_fire && !wr_hit) |=> (s_axi_bvalid && s_axi_bresp == `PSLEB_RESP_SLVERR && $stable(sleep_en_ff));
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("refused write changed state");
	property p_random_follow;
		@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> (random_power_off_ff == $past(sleep_en_ff[`PSLEB_BIT_RANDOM]));
	endproperty
	a_random_follow: assert property (p_random_follow) else $error("random power-off late");
	property p_gate_word;
		@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> (clk_gate_off_ff == $past(sleep_en_ff & `PSLEB_PERIPH_MASK & ~clk_req_eff));
	endproperty
	a_gate_word: assert property (p_gate_word) else $error("clock gate word wrong");
	property p_gate_restore;
		@(posedge aclk) disable iff (!aresetn)
		$fell(sleep_en_ff[28]) |=> !clk_gate_off_ff[28];
	endproperty
	a_gate_restore: assert property (p_gate_restore) else $error("clock not restored on wake");

	// Scenario covers
	c_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire && wr_hit);
	c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
	c_sleep: cover property (@(posedge aclk) disable iff (!aresetn) sys_sleep_ok_ff);
	c_random_off: cover property (@(posedge aclk) disable iff (!aresetn) $rose(random_power_off_ff));
	c_refused: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : psleb_top
`default_nettype wire

//--- tb/psleb_periph_model.sv
// Behavioural model of the peripherals that answer the sleep commands
`timescale 1ns/1ps
`default_nettype none
`include "psleb_defines.svh"
module psleb_periph_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] sleep_cmd,
	input  wire logic        random_off,
	input  wire logic [31:0] busy,
	input  wire logic        slow,
	output var  logic [31:0] clk_req
);
	logic [31:0] asleep_ff;
	logic [2:0]  tick_ff;

	// ==========================================================
	// Sleep entry: at once, or only on a tick when running slow
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			asleep_ff <= 32'h0000_0000;
			tick_ff   <= 3'h0;
		end else begin
			tick_ff   <= tick_ff + 3'h1;
			asleep_ff <= sleep_cmd & ((slow && tick_ff != 3'h0) ? asleep_ff : 32'hFFFF_FFFF);
		end
	end

	// Powered-off random source drops its request in the same cycle
	assign clk_req = busy & ~asleep_ff & `PSLEB_PERIPH_MASK & ~({31'h0, random_off} << 27);
endmodule : psleb_periph_model
`default_nettype wire

//--- tb/tb_peripheral_sleep_enable_bank.sv
// Self-checking testbench of the peripheral sleep-enable bank
`timescale 1ns/1ps
`default_nettype none
`include "psleb_defines.svh"
module tb_peripheral_sleep_enable_bank;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, slow;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, other_groups_asleep;
	logic        random_power_off_ff, crypto_reg_block_ff, pubkey_reg_block_ff, sys_sleep_ok_ff;
	logic [11:0] s_axi_awaddr, s_axi_araddr, a;
	logic [31:0] s_axi_wdata, s_axi_rdata, periph_clk_req, sleep_cmd_ff, clk_gate_off_ff, busy, exp_reg, rd, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	int          errors, compares;

	psleb_top u_psleb_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_clk_req,
		.other_groups_asleep, .sleep_cmd_ff, .clk_gate_off_ff, .random_power_off_ff, .crypto_reg_block_ff,
		.pubkey_reg_block_ff, .sys_sleep_ok_ff);

	psleb_periph_model u_psleb_periph_model (.aclk, .aresetn, .sleep_cmd(sleep_cmd_ff),
		.random_off(random_power_off_ff), .busy, .slow, .clk_req(periph_clk_req));

	// ==========================================================
	// Clock at 40 MHz
	always #12.5 aclk = ~aclk;

	// ==========================================================
	// Reporting
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("Counts: %0d compares, %0d errors", compares, errors);
		if (errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	// ==========================================================
	// One AXI4-Lite transfer; write when w is set, otherwise read
	task automatic bus(input logic w, input logic [11:0] adr, input logic [31:0] dat, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr  <= adr;
		s_axi_araddr  <= adr;
		s_axi_wdata   <= dat;
		s_axi_wstrb   <= s;
		s_axi_awvalid <= w;
		s_axi_wvalid  <= w;
		s_axi_bready  <= w;
		s_axi_arvalid <= !w;
		s_axi_rready  <= !w;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n > 50) begin
				chk(32'h0, 32'h1, "bus timeout");
				test_done();
			end
		end while (w ? s_axi_bvalid !== 1'b1 : s_axi_rvalid !== 1'b1);
		rsp = w ? s_axi_bresp : s_axi_rresp;
		rd = s_axi_rdata;
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask : bus

	// Register contents after a write with byte strobes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v, input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & `PSLEB_WRITE_MASK;
		return (o & ~m) | (v & m);
	endfunction : merge

	function automatic logic [1:0] resp_of(input logic [11:0] adr, input logic w);
		return (adr == `PSLEB_OFS_SLEEP_EN2 || (!w && adr == `PSLEB_OFS_CLK_REQ2)) ? `PSLEB_RESP_OKAY : `PSLEB_RESP_SLVERR;
	endfunction : resp_of

	// Let the peripherals settle, then compare every output and both registers
	task automatic check_outputs();
		logic [31:0] cmd;
		cmd = exp_reg & `PSLEB_PERIPH_MASK;
		repeat (20) @(posedge aclk);
		#1;
		chk(sleep_cmd_ff, cmd, "sleep command");
		chk(random_power_off_ff, exp_reg[27], "random off");
		chk(clk_gate_off_ff, cmd & ~periph_clk_req, "clock gate");
		chk(crypto_reg_block_ff, cmd[28] & ~periph_clk_req[28], "crypto block");
		chk(pubkey_reg_block_ff, cmd[26] & ~periph_clk_req[26], "pubkey block");
		chk(sys_sleep_ok_ff, cmd == `PSLEB_PERIPH_MASK && other_groups_asleep && periph_clk_req == 0, "sys");
		bus(1'b0, `PSLEB_OFS_CLK_REQ2, 32'h0, 4'h0);
		chk(rd, periph_clk_req, "request status");
		bus(1'b0, `PSLEB_OFS_SLEEP_EN2, 32'h0, 4'h0);
		chk(rd, exp_reg, "sleep register");
	endtask : check_outputs

	// ==========================================================
	// Main sequence: reset, corner writes, random traffic, reset again
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{busy, slow, other_groups_asleep, exp_reg, errors, compares} = '0;
		void'($urandom(32'ha7eec879));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		check_outputs();
		$display("test reset values done");
		for (int i = 0; i < 24; i++) begin
			@(posedge aclk);
			busy <= $urandom;
			slow <= i[0];
			other_groups_asleep <= (i < 3) | 1'($urandom);
			case (i)
				0: {a, d} = {`PSLEB_OFS_SLEEP_EN2, 32'hFFFF_FFFF};
				1: {a, d} = {`PSLEB_OFS_CLK_REQ2, 32'h0000_0000};
				2: {a, d} = {12'h100, 32'h0000_0000};
				3: {a, d} = {`PSLEB_OFS_SLEEP_EN2, 32'h0000_0000};
				default: begin
					a = $urandom_range(0, 3) == 0 ? 12'h030 : ($urandom_range(0, 2) == 0 ? 12'h028 : 12'h024);
					d = $urandom;
				end
			endcase
			bus(1'b1, a, d, i < 4 ? 4'hF : 4'($urandom));
			chk(rsp, resp_of(a, 1'b1), "write response");
			if (a == `PSLEB_OFS_SLEEP_EN2)
				exp_reg = merge(exp_reg, d, i < 4 ? 4'hF : s_axi_wstrb);
			bus(1'b0, a, 32'h0, 4'h0);
			chk(rsp, resp_of(a, 1'b0), "read response");
			if (a != `PSLEB_OFS_CLK_REQ2)
				chk(rd, a == `PSLEB_OFS_SLEEP_EN2 ? exp_reg : 32'h0, "read data");
			check_outputs();
			$display("test %0d done", i);
		end
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		exp_reg = 32'h0000_0000;
		check_outputs();
		$display("test second reset done");
		test_done();
	end
endmodule : tb_peripheral_sleep_enable_bank
`default_nettype wire
